/* shared/port_change_pkg.sv */
/*
  constants for the port change interrupt block: register indices on the
  internal register port, field positions, reset values and sync depth.
  assumes the serial front end presents whole-byte accesses to the block.
*/
package port_change_pkg;

  localparam int          PORT_W          = 8;
  localparam int          ADDR_W          = 4;
  localparam int          CNT_W           = 4;

  localparam logic [3:0]  ADDR_DIRECTION  = 4'h0;
  localparam logic [3:0]  ADDR_IRQ_ENABLE = 4'h2;
  localparam logic [3:0]  ADDR_DEFAULT    = 4'h3;
  localparam logic [3:0]  ADDR_SOURCE     = 4'h4;
  localparam logic [3:0]  ADDR_CONFIG     = 4'h5;
  localparam logic [3:0]  ADDR_FLAG       = 4'h7;
  localparam logic [3:0]  ADDR_CAPTURE    = 4'h8;
  localparam logic [3:0]  ADDR_PORT       = 4'h9;
  localparam logic [3:0]  ADDR_LATCH      = 4'ha;

  localparam int          CFG_CLEAR_SEL   = 0;
  localparam int          CFG_POLARITY    = 1;
  localparam int          CFG_OPEN_DRAIN  = 2;
  localparam int          CFG_SEQ_OFF     = 5;
  localparam logic [7:0]  CFG_WR_MASK     = 8'h27;

  localparam logic [7:0]  RST_LATCH       = 8'h00;
  localparam logic [7:0]  RST_DIRECTION   = 8'hff;
  localparam logic [7:0]  RST_ZERO        = 8'h00;

  // read data leaves msb first, so the lsb goes with the last of these edges
  localparam logic [3:0]  BITS_PER_READ   = 4'h8;
  localparam logic [1:0]  PRIME_CYCLES    = 2'h3;

endpackage

/* rtl/port_change_interrupt.sv */
/*
  interrupt-on-change logic, capture, flag and output latch of an 8-bit
  expander port, behind a byte-wide internal register port.
  assumes the serial front end pulses regWrEn/regRdEn once per byte in the
  clk domain and that the serial clock rises once per shifted read bit.
*/
// Operation
// - output latch register, reset zero, reads back latch not pins
// - interrupt output asserts on enabled pin change or default mismatch
// - one change-interrupt enable bit per pin
// - pin-change mode compares enabled pins against their previous value
// - default-compare mode compares enabled pins against default register bits
// - only enabled input pins interrupt; output pins never do
// - on interrupt the whole port value is copied into capture register
// - while pending, no new interrupt and no capture update
// - interrupt holds until capture or port read, chosen by clear-select
// - writes to capture or port register leave interrupt untouched
// - clearing read clears only after its lsb is shifted out
// - with pending change, port-read clear re-asserts and recaptures at once
// - pin-change reference becomes the new level once interrupt occurs
// - default-compare condition persists while pin differs, despite reads
// - interrupt driver push-pull high, push-pull low, or open-drain
// - open-drain bit forces open-drain and overrides polarity
// - polarity bit set means active high, clear means active low
// - clear-select one: capture read clears; zero: port read clears
// - flag register marks causing pins, read only, ignores writes
`timescale 1ns/1ps
module port_change_interrupt #(
  parameter int PORT_W = port_change_pkg::PORT_W
) (
  input  wire logic                               clk,
  input  wire logic                               rstn,
  input  wire logic                               ce,
  input  wire logic [port_change_pkg::ADDR_W-1:0] regAddr,
  input  wire logic                               regWrEn,
  input  wire logic [7:0]                         regWrData,
  input  wire logic                               regRdEn,
  output logic      [7:0]                         regRdData,
  input  wire logic                               serialClk,
  input  wire logic [PORT_W-1:0]                  portIn,
  output logic      [PORT_W-1:0]                  portOut,
  output logic      [PORT_W-1:0]                  portOe_n,
  output logic                                    irqOut,
  output logic                                    irqOe_n
);

  typedef struct packed {
    logic [PORT_W-1:0]                outLatch;
    logic [PORT_W-1:0]                direction;
    logic [PORT_W-1:0]                irqEnable;
    logic [PORT_W-1:0]                compareDefault;
    logic [PORT_W-1:0]                sourceSelect;
    logic [7:0]                       deviceConfig;
    logic [PORT_W-1:0]                flag;
    logic [PORT_W-1:0]                captured;
    logic [PORT_W-1:0]                prevRef;
    logic                             pending;
    logic [7:0]                       rdData;
    logic                             clearArmed;
    logic [port_change_pkg::CNT_W-1:0] bitCnt;
    logic [1:0]                       prime;
    logic [PORT_W-1:0]                portMeta;
    logic [PORT_W-1:0]                portSync;
    logic                             sckMeta;
    logic                             sckSync;
    logic                             sckPrev;
  } state_s;

  localparam state_s STATE_RST = '{
    outLatch:       port_change_pkg::RST_LATCH,
    direction:      port_change_pkg::RST_DIRECTION,
    irqEnable:      port_change_pkg::RST_ZERO,
    compareDefault: port_change_pkg::RST_ZERO,
    sourceSelect:   port_change_pkg::RST_ZERO,
    deviceConfig:   port_change_pkg::RST_ZERO,
    flag:           port_change_pkg::RST_ZERO,
    captured:       port_change_pkg::RST_ZERO,
    prevRef:        port_change_pkg::RST_ZERO,
    pending:        1'b0,
    rdData:         port_change_pkg::RST_ZERO,
    clearArmed:     1'b0,
    bitCnt:         '0,
    prime:          2'h0,
    portMeta:       port_change_pkg::RST_ZERO,
    portSync:       port_change_pkg::RST_ZERO,
    sckMeta:        1'b0,
    sckSync:        1'b0,
    sckPrev:        1'b0
  };

  logic   rstMeta_n;
  logic   rstSync_n;
  state_s state_reg;
  state_s state_next;

  // per-pin cause: mismatch against default or previous level, enabled inputs only
  function automatic logic [PORT_W-1:0] irqCause(
    input logic [PORT_W-1:0] level,
    input logic [PORT_W-1:0] prev,
    input logic [PORT_W-1:0] dflt,
    input logic [PORT_W-1:0] srcSel,
    input logic [PORT_W-1:0] enable,
    input logic [PORT_W-1:0] dir
  );
    logic [PORT_W-1:0] diff;
    diff = (srcSel & (level ^ dflt)) | (~srcSel & (level ^ prev));
    return diff & enable & dir;
  endfunction

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end
    else
    begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  always_comb
  begin
    logic [PORT_W-1:0] cause;
    logic              sckRise;
    logic              clearNow;
    logic              clearSel;
    logic              canTake;
    cause    = '0;
    sckRise  = 1'b0;
    clearNow = 1'b0;
    clearSel = 1'b0;
    canTake  = 1'b0;
    state_next = state_reg;

    state_next.portMeta = portIn;
    state_next.portSync = state_reg.portMeta;
    state_next.sckMeta  = serialClk;
    state_next.sckSync  = state_reg.sckMeta;
    state_next.sckPrev  = state_reg.sckSync;
    sckRise = state_reg.sckSync & ~state_reg.sckPrev;

    cause = irqCause(state_reg.portSync, state_reg.prevRef, state_reg.compareDefault,
                     state_reg.sourceSelect, state_reg.irqEnable, state_reg.direction);

    // the clearing register follows the select bit at read time
    clearSel = state_reg.deviceConfig[port_change_pkg::CFG_CLEAR_SEL];
    if (regRdEn)
    begin
      case (regAddr)
        port_change_pkg::ADDR_DIRECTION:  state_next.rdData = state_reg.direction;
        port_change_pkg::ADDR_IRQ_ENABLE: state_next.rdData = state_reg.irqEnable;
        port_change_pkg::ADDR_DEFAULT:    state_next.rdData = state_reg.compareDefault;
        port_change_pkg::ADDR_SOURCE:     state_next.rdData = state_reg.sourceSelect;
        port_change_pkg::ADDR_CONFIG:     state_next.rdData = state_reg.deviceConfig;
        port_change_pkg::ADDR_FLAG:       state_next.rdData = state_reg.flag;
        port_change_pkg::ADDR_CAPTURE:    state_next.rdData = state_reg.captured;
        port_change_pkg::ADDR_PORT:       state_next.rdData = state_reg.portSync;
        port_change_pkg::ADDR_LATCH:      state_next.rdData = state_reg.outLatch;
        default:                          state_next.rdData = port_change_pkg::RST_ZERO;
      endcase
      if ((clearSel && regAddr == port_change_pkg::ADDR_CAPTURE) ||
          (!clearSel && regAddr == port_change_pkg::ADDR_PORT))
      begin
        state_next.clearArmed = 1'b1;
        state_next.bitCnt     = '0;
      end
    end

    // count shifted bits; the clear lands only after the lsb edge
    if (state_reg.clearArmed && sckRise)
    begin
      state_next.bitCnt = state_reg.bitCnt + 1'b1;
      if (state_reg.bitCnt == port_change_pkg::BITS_PER_READ - 1'b1)
      begin
        clearNow              = 1'b1;
        state_next.clearArmed = 1'b0;
      end
    end

    // writes to flag and capture fall through; port writes go to the latch
    if (regWrEn)
    begin
      case (regAddr)
        port_change_pkg::ADDR_DIRECTION:  state_next.direction = regWrData;
        port_change_pkg::ADDR_IRQ_ENABLE: state_next.irqEnable = regWrData;
        port_change_pkg::ADDR_DEFAULT:    state_next.compareDefault = regWrData;
        port_change_pkg::ADDR_SOURCE:     state_next.sourceSelect = regWrData;
        port_change_pkg::ADDR_CONFIG:
          state_next.deviceConfig = regWrData & port_change_pkg::CFG_WR_MASK;
        port_change_pkg::ADDR_PORT:       state_next.outLatch = regWrData;
        port_change_pkg::ADDR_LATCH:      state_next.outLatch = regWrData;
        default:                          state_next.outLatch = state_reg.outLatch;
      endcase
    end

    if (clearNow)
    begin
      state_next.pending = 1'b0;
      state_next.flag    = '0;
    end

    // inputs need the sync depth to settle before they can serve as reference
    if (state_reg.prime != port_change_pkg::PRIME_CYCLES)
    begin
      state_next.prime   = state_reg.prime + 1'b1;
      state_next.prevRef = state_reg.portSync;
    end
    else
    begin
      // a clear and a new cause in one cycle re-raise at once: the set wins
      canTake = ~state_reg.pending | clearNow;
      if (canTake && (|cause))
      begin
        state_next.pending  = 1'b1;
        state_next.captured = state_reg.portSync;
        state_next.flag     = cause;
        state_next.prevRef  = state_reg.portSync;
      end
      else
      begin
        // unmonitored pins track so enabling one later raises nothing stale
        state_next.prevRef = (state_reg.prevRef & state_reg.irqEnable & state_reg.direction)
                           | (state_reg.portSync & ~(state_reg.irqEnable & state_reg.direction));
      end
    end

    if (!ce)
    begin
      state_next = state_reg;
    end
  end

  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      state_reg <= STATE_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign regRdData = state_reg.rdData;
  assign portOut   = state_reg.outLatch;
  assign portOe_n  = state_reg.direction;

  always_comb
  begin
    if (state_reg.deviceConfig[port_change_pkg::CFG_OPEN_DRAIN])
    begin
      irqOut  = 1'b0;
      irqOe_n = ~state_reg.pending;
    end
    else
    begin
      // polarity set drives pending as is; clear drives it inverted
      irqOut  = state_reg.deviceConfig[port_change_pkg::CFG_POLARITY] ~^ state_reg.pending;
      irqOe_n = 1'b0;
    end
  end

endmodule

/* verif/port_change_checker_assertions.sv */
/*
  assertions on the ports of the port change block.
  assumes whole-byte register accesses; a config copy is kept from writes.
*/
`timescale 1ns/1ps
module port_change_checker #(
  parameter int PORT_W = 8
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              ce,
  input wire logic [3:0]        regAddr,
  input wire logic              regWrEn,
  input wire logic [7:0]        regWrData,
  input wire logic              regRdEn,
  input wire logic [7:0]        regRdData,
  input wire logic              serialClk,
  input wire logic [PORT_W-1:0] portIn,
  input wire logic [PORT_W-1:0] portOut,
  input wire logic [PORT_W-1:0] portOe_n,
  input wire logic              irqOut,
  input wire logic              irqOe_n
);
  logic [7:0] cfgReg;
  logic [1:0] cfgAge;
  logic       irqAct;
  logic       capPortWr;
  assign irqAct = cfgReg[2] ? !irqOe_n : (irqOut == cfgReg[1]);
  assign capPortWr = ce && regWrEn
    && (regAddr == port_change_pkg::ADDR_CAPTURE || regAddr == port_change_pkg::ADDR_PORT);
  // irq drive lags a config write, so mode checks wait for the copy to age
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfgReg <= 8'h00;
      cfgAge <= 2'h0;
    end
    else if (ce && regWrEn && regAddr == port_change_pkg::ADDR_CONFIG)
    begin
      cfgReg <= regWrData & port_change_pkg::CFG_WR_MASK;
      cfgAge <= 2'h0;
    end
    else if (cfgAge != 2'h3)
      cfgAge <= cfgAge + 2'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_latch_drive:
    assert property (ce && regWrEn && regAddr == port_change_pkg::ADDR_LATCH
      |=> portOut == $past(regWrData)) else $error("latch write not on pins");
  chk_latch_readback:
    assert property (ce && regRdEn && regAddr == port_change_pkg::ADDR_LATCH
      |=> regRdData == portOut) else $error("latch read differs");
  chk_port_read:
    assert property ($stable(portIn)[*4] ##0 (ce && regRdEn
      && regAddr == port_change_pkg::ADDR_PORT) |=> regRdData == $past(portIn))
      else $error("port read differs from pins");
  chk_read_hold:
    assert property (!(ce && regRdEn) |=> $stable(regRdData)) else $error("read data moved");
  chk_od_drive:
    assert property (cfgReg[2] && cfgAge == 2'h3 |-> !irqOut) else $error("open drain drives");
  chk_pp_drive:
    assert property (!cfgReg[2] && cfgAge == 2'h3 |-> !irqOe_n) else $error("push pull off");
  chk_clear_wait:
    assert property ((irqAct && !serialClk && !regWrEn && cfgAge == 2'h3)[*6] |=> irqAct)
      else $error("irq cleared without shifting");
  chk_write_no_clear:
    assert property (irqAct && !serialClk && cfgAge == 2'h3 && capPortWr |=> irqAct)
      else $error("write cleared irq");
endmodule
bind port_change_interrupt port_change_checker #(.PORT_W(PORT_W)) chk_inst (.clk(clk),
  .rstn(rstn), .ce(ce), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
  .regRdEn(regRdEn), .regRdData(regRdData), .serialClk(serialClk), .portIn(portIn),
  .portOut(portOut), .portOe_n(portOe_n), .irqOut(irqOut), .irqOe_n(irqOe_n));

/* verif/serial_host_model.sv */
/*
  host side bit clock: eight read bit clocks per request, low when idle.
  assumes go is a short pulse from the bench.
*/
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic go,
  output logic      serialClk,
  output logic      busy
);
  initial
  begin
    serialClk = 1'b0;
    busy = 1'b0;
  end
  // odd offset keeps the bit clock unrelated to clk; lsb leaves on the eighth rise
  always @(posedge go)
  begin
    busy = 1'b1;
    #37;
    repeat (8)
    begin
      #80 serialClk = 1'b1;
      #80 serialClk = 1'b0;
    end
    busy = 1'b0;
  end
endmodule

/* verif/test_port_change_interrupt.sv */
/*
  bench of the port change block: register tasks, pin stimulus, read clears.
  assumes the checker is bound; ce is dropped once to check the freeze.
*/
`timescale 1ns/1ps
module test_port_change_interrupt;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       ce = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic       regWrEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic       regRdEn = 1'b0;
  logic [7:0] regRdData, portOut, portOe_n, rv;
  logic [7:0] portIn = 8'h00;
  logic       serialClk, shiftGo = 1'b0, shiftBusy, irqOut, irqOe_n;
  int         fails = 0;
  int         tests_run = 0;
  always #5 clk = ~clk;
  port_change_interrupt port_change_interrupt_inst (.clk(clk), .rstn(rstn), .ce(ce),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .serialClk(serialClk), .portIn(portIn), .portOut(portOut),
    .portOe_n(portOe_n), .irqOut(irqOut), .irqOe_n(irqOe_n));
  serial_host_model serial_host_model_inst (.go(shiftGo), .serialClk(serialClk),
    .busy(shiftBusy));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    d = regRdData;
  endtask
  // a read followed by its eight bit clocks, then time for the clear to land
  task automatic rdShift(input logic [3:0] a);
    rd(a, rv);
    shiftGo = 1'b1;
    @(negedge clk);
    shiftGo = 1'b0;
    repeat (400) if (shiftBusy) @(negedge clk);
    repeat (8) @(negedge clk);
  endtask
  task automatic pins(input logic [7:0] v);
    portIn = v;
    repeat (8) @(negedge clk);
  endtask
  task automatic report_and_stop;
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    fails++;
    report_and_stop();
  end
  initial
  begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    pins(8'h00);
    chk("irq", {irqOut, irqOe_n}, 8'h02);
    chk("dir", portOe_n, 8'hff);
    rd(port_change_pkg::ADDR_LATCH, rv);
    chk("latch", rv, 8'h00);
    rd(4'hf, rv);
    chk("unmapped", rv, 8'h00);
    wr(port_change_pkg::ADDR_LATCH, 8'ha5);
    rd(port_change_pkg::ADDR_LATCH, rv);
    chk("latch", rv, 8'ha5);
    chk("pins", portOut, 8'ha5);
    // a write while ce is low must leave the latch untouched
    ce = 1'b0;
    wr(port_change_pkg::ADDR_LATCH, 8'h3c);
    ce = 1'b1;
    chk("frozen", portOut, 8'ha5);
    wr(port_change_pkg::ADDR_IRQ_ENABLE, 8'h01);
    pins(8'h03);
    chk("irq", {irqOut, irqOe_n}, 8'h00);
    rd(port_change_pkg::ADDR_CAPTURE, rv);
    chk("capture", rv, 8'h03);
    wr(port_change_pkg::ADDR_FLAG, 8'hff);
    rd(port_change_pkg::ADDR_FLAG, rv);
    chk("flag", rv, 8'h01);
    pins(8'h00);
    rd(port_change_pkg::ADDR_CAPTURE, rv);
    chk("capture", rv, 8'h03);
    wr(port_change_pkg::ADDR_CAPTURE, 8'h55);
    chk("irq", {irqOut, irqOe_n}, 8'h00);
    rdShift(port_change_pkg::ADDR_PORT);
    chk("irq", {irqOut, irqOe_n}, 8'h00);
    rd(port_change_pkg::ADDR_CAPTURE, rv);
    chk("capture", rv, 8'h00);
    wr(port_change_pkg::ADDR_CONFIG, 8'h01);
    rdShift(port_change_pkg::ADDR_PORT);
    chk("irq", {irqOut, irqOe_n}, 8'h00);
    rdShift(port_change_pkg::ADDR_CAPTURE);
    chk("irq", {irqOut, irqOe_n}, 8'h02);
    wr(port_change_pkg::ADDR_SOURCE, 8'h01);
    wr(port_change_pkg::ADDR_DIRECTION, 8'hfe);
    chk("dir", portOe_n, 8'hfe);
    pins(8'h01);
    chk("irq", {irqOut, irqOe_n}, 8'h02);
    wr(port_change_pkg::ADDR_DIRECTION, 8'hff);
    pins(8'h01);
    chk("irq", {irqOut, irqOe_n}, 8'h00);
    rdShift(port_change_pkg::ADDR_CAPTURE);
    chk("irq", {irqOut, irqOe_n}, 8'h00);
    wr(port_change_pkg::ADDR_CONFIG, 8'h05);
    pins(8'h00);
    chk("irq", {irqOut, irqOe_n}, 8'h00);
    rdShift(port_change_pkg::ADDR_CAPTURE);
    chk("irq", {irqOut, irqOe_n}, 8'h01);
    wr(port_change_pkg::ADDR_CONFIG, 8'h03);
    pins(8'h00);
    chk("irq", {irqOut, irqOe_n}, 8'h00);
    pins(8'h01);
    chk("irq", {irqOut, irqOe_n}, 8'h02);
    report_and_stop();
  end
endmodule
